// ---- shtcp_regs.vh ----
// Purpose: Constants for the sensor I2C command port.
// Assumes: 250 MHz system clock.
// Notes: Times are given in their own unit, cycle counts derive from them.
`ifndef SHTCP_REGS_VH
`define SHTCP_REGS_VH
`define SHTCP_ADDR_LOW 7'h44
`define SHTCP_ADDR_HIGH 7'h45
`define SHTCP_CLK_MHZ 250
`define SHTCP_RESET_PULSE_US 1
`define SHTCP_RESET_PULSE_CYC (`SHTCP_RESET_PULSE_US * `SHTCP_CLK_MHZ)
`define SHTCP_CMD_GAP_US 1000
`define SHTCP_CMD_GAP_CYC (`SHTCP_CMD_GAP_US * `SHTCP_CLK_MHZ)
`define SHTCP_POWERUP_US 1000
`define SHTCP_POWERUP_CYC (`SHTCP_POWERUP_US * `SHTCP_CLK_MHZ)
`define SHTCP_STRETCH_BIT 11
`define SHTCP_CRC_INIT 8'hff
`define SHTCP_CRC_POLY 8'h31
`endif

// ---- shtcp_port.v ----
// Purpose: I2C target command port of a humidity and temperature sensor.
// Assumes: SCL is far slower than sys_clk, so edges are found by sampling.
// Notes: Command decode beyond framing, checksum and the stretch bit is left to the core.
// Operation
// - Any bus clock rate up to 1000 kHz.
// - Command selects clock stretching usage.
// - Address 0x44 strap low, 0x45 high.
// - Header: address high seven, direction LSB.
// - Alarm output high on alarm condition.
// - Reset pin low at least one microsecond.
// - Commands are 16-bit words with checksum.
// - Each data word followed by checksum byte.
// - Bad checksum byte NACKed, after the command is already issued.
// - Commands accepted only after power-up idle.
// - Transactions framed by start and stop.
// - Idle entered automatically, no user control.
// - Acknowledge after falling edge of eighth bit.
// - Measurement starts at command acknowledge.
// - Lines open-drain, only pulled low.
`timescale 1ns/10ps
`include "shtcp_regs.vh"
module shtcp_port #(
    parameter PU_CYC = `SHTCP_POWERUP_CYC,
    parameter GAP_CYC = `SHTCP_CMD_GAP_CYC,
    parameter RST_CYC = `SHTCP_RESET_PULSE_CYC
) (
    // Clock and reset
    input wire sys_clk,
    input wire rst_n,
    // Bus pins
    input wire sclIn,
    output reg sclOut,
    output reg sclOe,
    input wire sdaIn,
    output reg sdaOut,
    output reg sdaOe,
    // Strap, external reset and alarm
    input wire busIdStrap,
    input wire external_reset_low_in,
    input wire alarmCond,
    output reg alertOut,
    // Core side
    input wire measBusy,
    output reg [15:0] cmdWord,
    output reg cmdStrobe,
    output reg stretchSel,
    output reg idleOut
);
    localparam ST_IDLE = 5'h01;
    localparam ST_BYTE = 5'h02;
    localparam ST_ACK = 5'h04;
    localparam ST_SKIP = 5'h08;
    localparam ST_WAIT = 5'h10;

    // CRC-8 step over one byte, also used on the command word's halves.
    function [7:0] crc8;
        input [7:0] crcIn;
        input [7:0] dat;
        integer i;
        reg [7:0] c;
        begin
            c = crcIn ^ dat;
            for (i = 0; i < 8; i = i + 1) begin
                c = c[7] ? ((c << 1) ^ `SHTCP_CRC_POLY) : (c << 1);
            end
            crc8 = c;
        end
    endfunction

    reg rstS1_q, rstS2_q;
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rstS1_q <= 1'b0;
            rstS2_q <= 1'b0;
        end else begin
            rstS1_q <= 1'b1;
            rstS2_q <= rstS1_q;
        end
    end

    // Two-flop synchronisers on every pin input.
    reg [4:0] syA_q, syB_q;
    reg sclP_q, sdaP_q;
    always @(posedge sys_clk or negedge rstS2_q) begin
        if (!rstS2_q) begin
            // Alarm rests low and the other pins rest high, so no false edge follows reset.
            syA_q <= 5'h0f;
            syB_q <= 5'h0f;
            sclP_q <= 1'b1;
            sdaP_q <= 1'b1;
        end else begin
            syA_q <= {alarmCond, external_reset_low_in, busIdStrap, sdaIn, sclIn};
            syB_q <= syA_q;
            sclP_q <= syB_q[0];
            sdaP_q <= syB_q[1];
        end
    end
    wire scl = syB_q[0];
    wire sda = syB_q[1];
    wire strap = syB_q[2];
    wire extRstN = syB_q[3];
    wire sclRise = scl & ~sclP_q;
    wire sclFall = ~scl & sclP_q;
    wire startCond = scl & sclP_q & sdaP_q & ~sda;
    wire stopCond = scl & sclP_q & ~sdaP_q & sda;

    reg [31:0] rstCnt_q;
    reg softRst_q;
    reg [31:0] puCnt_q;
    reg ready_q;
    reg [31:0] gapCnt_q;
    reg [4:0] st_q;
    reg [3:0] bitCnt_q;
    reg [7:0] sh_q;
    reg [1:0] byteIdx_q;
    reg [6:0] myAddr_q;
    reg ackOk_q;
    reg [7:0] crc_q;
    reg [15:0] cmd_q;

    // Acknowledge decision for the byte just completed, settled before the line is touched.
    wire hdrMatch = ready_q && sh_q[7:1] == myAddr_q && !sh_q[0];
    wire gapOver = gapCnt_q == 32'h0;
    wire crcMatch = crc8(crc_q, cmd_q[7:0]) == sh_q;
    wire ackNow = (byteIdx_q == 2'h0) ? hdrMatch : (byteIdx_q == 2'h1) ? gapOver : (byteIdx_q == 2'h2) | crcMatch;

    always @(posedge sys_clk or negedge rstS2_q) begin
        if (!rstS2_q) begin
            rstCnt_q <= 32'h0;
            softRst_q <= 1'b0;
        end else if (!extRstN) begin
            if (rstCnt_q < RST_CYC - 1)
                rstCnt_q <= rstCnt_q + 32'h1;
            else
                softRst_q <= 1'b1;
        end else begin
            rstCnt_q <= 32'h0;
            softRst_q <= 1'b0;
        end
    end

    always @(posedge sys_clk or negedge rstS2_q) begin
        if (!rstS2_q) begin
            puCnt_q <= 32'h0;
            ready_q <= 1'b0;
            gapCnt_q <= 32'h0;
            st_q <= ST_IDLE;
            bitCnt_q <= 4'h0;
            sh_q <= 8'h0;
            byteIdx_q <= 2'h0;
            myAddr_q <= `SHTCP_ADDR_LOW;
            ackOk_q <= 1'b0;
            crc_q <= `SHTCP_CRC_INIT;
            cmd_q <= 16'h0;
            sdaOut <= 1'b0;
            sdaOe <= 1'b0;
            sclOut <= 1'b0;
            sclOe <= 1'b0;
            alertOut <= 1'b0;
            cmdWord <= 16'h0;
            cmdStrobe <= 1'b0;
            stretchSel <= 1'b0;
            idleOut <= 1'b0;
        end else if (softRst_q) begin
            puCnt_q <= 32'h0;
            ready_q <= 1'b0;
            st_q <= ST_IDLE;
            sdaOe <= 1'b0;
            sclOe <= 1'b0;
            cmdStrobe <= 1'b0;
            idleOut <= 1'b0;
            alertOut <= syB_q[4];
        end else begin
            cmdStrobe <= 1'b0;
            sdaOut <= 1'b0;
            sclOut <= 1'b0;
            sclOe <= 1'b0; // Stretching is done by the readout path, not here.
            alertOut <= syB_q[4];
            if (!ready_q) begin
                if (puCnt_q < PU_CYC - 1)
                    puCnt_q <= puCnt_q + 32'h1;
                else
                    ready_q <= 1'b1;
            end
            if (gapCnt_q != 32'h0)
                gapCnt_q <= gapCnt_q - 32'h1;
            idleOut <= ready_q & (st_q == ST_IDLE) & ~measBusy;
            if (startCond) begin
                st_q <= ST_BYTE;
                bitCnt_q <= 4'h0;
                byteIdx_q <= 2'h0;
                sdaOe <= 1'b0;
                myAddr_q <= strap ? `SHTCP_ADDR_HIGH : `SHTCP_ADDR_LOW;
            end else if (stopCond) begin
                st_q <= ST_IDLE;
                sdaOe <= 1'b0;
            end else begin
                case (st_q)
                    ST_IDLE: begin
                        sdaOe <= 1'b0;
                    end
                    ST_BYTE: begin
                        if (sclRise) begin
                            sh_q <= {sh_q[6:0], sda};
                            bitCnt_q <= bitCnt_q + 4'h1;
                        end else if (sclFall && bitCnt_q == 4'h8) begin
                            // Eighth bit complete. Counting to eight keeps the fall after a start from acting.
                            bitCnt_q <= 4'h0;
                            ackOk_q <= ackNow;
                            sdaOe <= ackNow;
                            if (byteIdx_q == 2'h1) begin
                                cmd_q[15:8] <= sh_q;
                                crc_q <= crc8(`SHTCP_CRC_INIT, sh_q);
                            end
                            if (byteIdx_q == 2'h2)
                                cmd_q[7:0] <= sh_q;
                            if (byteIdx_q == 2'h0 && !ackNow)
                                st_q <= ST_SKIP;
                            else
                                st_q <= ST_ACK;
                        end
                    end
                    ST_ACK: begin
                        if (!ackOk_q)
                            sdaOe <= 1'b0;
                        if (sclFall) begin
                            sdaOe <= 1'b0;
                            if (byteIdx_q == 2'h2 && ackOk_q) begin
                                // Command acknowledged: start the core now.
                                cmdWord <= cmd_q;
                                cmdStrobe <= 1'b1;
                                stretchSel <= cmd_q[`SHTCP_STRETCH_BIT];
                                gapCnt_q <= GAP_CYC;
                            end
                            if (byteIdx_q == 2'h3)
                                st_q <= ST_WAIT;
                            else begin
                                st_q <= ackOk_q ? ST_BYTE : ST_SKIP;
                                byteIdx_q <= byteIdx_q + 2'h1;
                            end
                        end
                    end
                    ST_SKIP: begin
                        sdaOe <= 1'b0;
                    end
                    ST_WAIT: begin
                        sdaOe <= 1'b0;
                    end
                    default: begin
                        st_q <= ST_IDLE;
                    end
                endcase
            end
        end
    end
endmodule // shtcp_port

// ---- shtcp_checker.sv ----
// Purpose: Pin-level assertions for shtcp_port.
// Assumes: Bound to the port module.
// Notes: Lags match the registered outputs.
`timescale 1ns/10ps
module shtcp_checker #(parameter PU_CYC = 100) (
    // Clock and reset
    input wire sys_clk,
    input wire rst_n,
    // Bus side
    input wire sclIn,
    input wire sclOut,
    input wire sclOe,
    input wire sdaOut,
    input wire sdaOe,
    // Alarm and core side
    input wire alarmCond,
    input wire alertOut,
    input wire measBusy,
    input wire [15:0] cmdWord,
    input wire cmdStrobe,
    input wire stretchSel,
    input wire idleOut
);
    int puCnt;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // This count starts before the port's own, so it only bounds early answers.
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) puCnt <= 0;
        else if (puCnt < PU_CYC) puCnt <= puCnt + 1;
    end
    a_pull_low_only: assert property ((sdaOe || sclOe) |-> !(sdaOut || sclOut)) else $error("line driven high");
    a_ack_edge_low: assert property ($rose(sdaOe) || $fell(sdaOe) |-> !sclIn) else $error("ack moved, SCL high");
    a_ack_holds_clock: assert property (sdaOe && $rose(sclIn) |-> sdaOe [*8]) else $error("ack dropped early");
    a_strobe_one_cycle: assert property (cmdStrobe |=> !cmdStrobe) else $error("strobe too long");
    a_stretch_bit: assert property (cmdStrobe |-> stretchSel == cmdWord[11]) else $error("stretch select wrong");
    a_busy_not_idle: assert property (measBusy [*3] |-> !idleOut) else $error("idle while busy");
    a_no_early_ack: assert property (puCnt < PU_CYC |-> !sdaOe) else $error("ack before power-up");
    a_alert_follows: assert property (puCnt > 8 |-> alertOut == $past(alarmCond, 3)) else $error("alert lag");
endmodule // shtcp_checker

// ---- shtcp_mst.sv ----
// Purpose: Bus master model for the command port.
// Assumes: SCL period 80 ns, twenty system clocks.
// Notes: Released lines read high through the pull-ups.
`timescale 1ns/10ps
module shtcp_mst (
    // Clock and bus
    input wire sys_clk,
    input wire sdaLine,
    output logic sclDrv,
    output logic sdaDrv
);
    // Both lines rest released, so SCL stands still between frames.
    initial begin
        sclDrv = 1'h1;
        sdaDrv = 1'h1;
    end
    task q;
        repeat (5) @(negedge sys_clk);
    endtask
    task startCond;
        sdaDrv = 1'h0;
        q;
        sclDrv = 1'h0;
        q;
    endtask
    task stopCond;
        sdaDrv = 1'h0;
        q;
        sclDrv = 1'h1;
        q;
        sdaDrv = 1'h1;
        q;
    endtask
    // Eight data bits, then SDA is released for the ninth clock.
    task automatic sendByte(input logic [7:0] b, output logic ack);
        for (int i = 8; i >= 0; i--) begin
            sdaDrv = (i > 0) ? b[i - 1] : 1'h1;
            q;
            sclDrv = 1'h1;
            q;
            ack = sdaLine;
            q;
            sclDrv = 1'h0;
            q;
        end
    endtask
endmodule // shtcp_mst

// ---- shtcp_port_bench.sv ----
// Purpose: Self-checking bench for shtcp_port.
// Assumes: Long counts are shortened by parameters.
// Notes: Commands mix fixed corners and random words.
`timescale 1ns/10ps
module shtcp_port_bench;
    localparam int PU = 1000, GAP = 3000, RST = 50;
    logic sys_clk = 1'h0, rst_n = 1'h0, busIdStrap = 1'h0, external_reset_low_in = 1'h1;
    logic alarmCond = 1'h0, measBusy = 1'h0;
    wire sclOut, sclOe, sdaOut, sdaOe, alertOut, cmdStrobe, stretchSel, idleOut, sclDrv, sdaDrv;
    wire [15:0] cmdWord;
    wire sclLine = sclDrv & ~(sclOe & ~sclOut);
    wire sdaLine = sdaDrv & ~(sdaOe & ~sdaOut);
    logic [15:0] rnd = 16'hecd7;
    int mismatches = 0, total_checks = 0, strobes = 0;
    shtcp_port #(.PU_CYC(PU), .GAP_CYC(GAP), .RST_CYC(RST)) shtcp_port_inst (.sys_clk, .rst_n, .sclIn(sclLine),
        .sclOut, .sclOe, .sdaIn(sdaLine), .sdaOut, .sdaOe, .busIdStrap, .external_reset_low_in, .alarmCond, .alertOut,
        .measBusy, .cmdWord, .cmdStrobe, .stretchSel, .idleOut);
    shtcp_mst shtcp_mst_inst (.sys_clk, .sdaLine, .sclDrv, .sdaDrv);
    initial forever #2 sys_clk = ~sys_clk;
    function automatic logic [15:0] nxt(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    always @(negedge sys_clk) begin
        rnd <= nxt(rnd);
        alarmCond <= rst_n & rnd[0];
    end
    // Counted at the falling edge, where the one-cycle strobe has settled.
    always @(negedge sys_clk) if (cmdStrobe === 1'h1) strobes++;
    function automatic logic [7:0] crc8(input logic [15:0] w);
        logic [7:0] c;
        c = 8'hff;
        for (int i = 15; i >= 0; i--) c = {c[6:0], 1'h0} ^ ((c[7] ^ w[i]) ? 8'h31 : 8'h00);
        return c;
    endfunction
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict;
        $display("checks=%0d mismatches=%0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic txn(input logic [7:0] hdr, input logic [15:0] cmd, input logic [7:0] crc, input int n,
        input logic [3:0] exp);
        logic [7:0] b[4];
        logic [3:0] a;
        b = '{hdr, cmd[15:8], cmd[7:0], crc};
        a = 4'hf;
        shtcp_mst_inst.startCond();
        for (int i = 0; i < n; i++) shtcp_mst_inst.sendByte(b[i], a[i]);
        shtcp_mst_inst.stopCond();
        chk(a, exp);
    endtask
    initial begin
        logic [15:0] c;
        logic [6:0] own;
        repeat (6) @(negedge sys_clk);
        rst_n = 1'h1;
        repeat (10) @(negedge sys_clk);
        txn(8'h88, 16'h0, 8'h0, 1, 4'hf);
        repeat (PU) @(negedge sys_clk);
        chk(idleOut, 1'h1);
        measBusy = 1'h1;
        repeat (5) @(negedge sys_clk);
        chk(idleOut, 1'h0);
        measBusy = 1'h0;
        for (int i = 0; i < 4; i++) begin
            c = (i == 0) ? 16'h2c06 : (i == 1) ? 16'h2400 : rnd;
            busIdStrap = i[0];
            own = 7'h44 | 7'(i[0]);
            txn({own ^ 7'h01, 1'h0}, c, 8'h0, 1, 4'hf);
            txn({own, 1'h0}, c, crc8(c), 4, 4'h0);
            chk(cmdWord, c);
            chk(stretchSel, c[11]);
            chk(16'(strobes), 16'(i + 1));
            txn({own, 1'h0}, c, crc8(c), 3, 4'he);
            repeat (GAP) @(negedge sys_clk);
        end
        busIdStrap = 1'h0;
        txn(8'h89, c, 8'h0, 1, 4'hf);
        txn(8'h88, c, crc8(c) ^ 8'h01, 4, 4'h8);
        external_reset_low_in = 1'h0;
        repeat (RST + 5) @(negedge sys_clk);
        external_reset_low_in = 1'h1;
        txn(8'h88, c, 8'h0, 1, 4'hf);
        repeat (PU) @(negedge sys_clk);
        txn(8'h88, c, 8'h0, 1, 4'he);
        give_verdict();
    end
endmodule // shtcp_port_bench
bind shtcp_port shtcp_checker #(.PU_CYC(PU_CYC)) shtcp_checker_inst (.sys_clk, .rst_n, .sclIn, .sclOut, .sclOe,
    .sdaOut, .sdaOe, .alarmCond, .alertOut, .measBusy, .cmdWord, .cmdStrobe, .stretchSel, .idleOut);
